// [src/dpc_core.sv]
// digital loop core: two phase detectors, loop-filter counter, add/delete
// assumes pclk at 40 MHz, all loop pins asynchronous to it and much slower
// assumes the apb master holds each request until pready is seen high
`timescale 1ns/1ps

// Function
// RL1: xor detector output high when its two inputs differ, low otherwise
// RL2: edge detector set by compare falling edge, cleared by reference falling edge
// RL3: all modulus selects low inhibits the loop-filter counter entirely
// RL4: select value n gives counter modulus two to the power n plus two
// RL5: all selects high makes the counter seventeen stages long
// RL6: controlling logic may change modulus select while running
// RL7: loop-filter counter advances on its own counter clock
// RL8: up-count wrap emits one carry pulse to the add/delete stage
// RL9: down-count wrap emits one borrow pulse to the add/delete stage
// RL10: outside logic routes chosen detector output to count direction
// RL11: without carries or borrows add/delete output is half its clock
// RL12: each carry or borrow adds or removes exactly one output pulse; a second pulse of one kind arriving while one waits merges into it
// RL13: add/delete clock runs at 2N times loop centre frequency
// RL14: outside logic supplies the divide-by-N feedback counter
// RL15: xor detector inputs should have fifty percent duty factor
// RL16: zero phase error gives square wave detector output
// RL17: carry inserts one output pulse, borrow deletes one
// RL18: counter samples direction and enable on its clock edge
// RL19: reset clears counter and add/delete state without external help
module dpc_core
  import dpc_pkg::*;
(
  input wire logic pclk, // core clock, 40 MHz
  input wire logic presetn, // asynchronous reset, active low
  input wire dpc_pkg::dpc_apb_req_s apb_req, // apb request
  output dpc_pkg::dpc_apb_rsp_s apb_rsp, // apb answer
  input wire logic xor_ref_in, // xor detector reference
  input wire logic edge_ref_in, // edge detector reference
  input wire logic compare_in, // feedback from divide-by-N
  input wire logic loop_filter_counter_clock, // counter clock pin
  input wire logic add_delete_clock, // add/delete clock pin
  input wire logic count_dir_in, // count direction, high counts down
  output logic xor_detector_out, // xor detector result
  output logic edge_detector_out, // edge detector result
  output logic add_delete_out, // add/delete stage output
  output logic carry_out, // one-cycle carry pulse
  output logic borrow_out // one-cycle borrow pulse
);
  import dpc_pkg::*;

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  // synchroniser, detector, counter, add/delete and bus state in one record
  typedef struct packed {
    logic [DPC_NSYNC-1:0] sync1;
    logic [DPC_NSYNC-1:0] sync2;
    logic [DPC_NSYNC-1:0] prev;
    logic xor_out;
    logic edge_out;
    logic ad_out;
    logic carry;
    logic borrow;
    logic carry_pend;
    logic borrow_pend;
    logic dir_q;
    dpc_ad_e ad_st;
    logic [DPC_CNT_W-1:0] count;
    logic [DPC_CTRL_MOD_W-1:0] mod_sel;
    logic ctr_en;
    dpc_apb_rsp_s rsp;
  } dpc_state_s;

  dpc_state_s st;
  dpc_state_s next_st;

  // counter wrap value for a given select, all ones below the modulus
  function automatic logic [DPC_CNT_W-1:0] dpc_mask(input logic [3:0] n);
    logic [DPC_CNT_W:0] m;
    m = ((DPC_CNT_W+1)'(1) << (5'(n) + 5'(DPC_MOD_OFFSET))) - (DPC_CNT_W+1)'(1); // RL4 RL5
    // the extra top bit absorbs the shift, so n of 15 still yields seventeen ones
    return m[DPC_CNT_W-1:0];
  endfunction : dpc_mask

  // -----------------------------------------------------------------
  // combinational helpers
  // -----------------------------------------------------------------
  logic k_rise;
  logic id_rise;
  logic id_fall;
  logic cmp_fall;
  logic eref_fall;
  logic [DPC_CNT_W-1:0] mask;
  logic [DPC_CNT_W-1:0] cur;
  logic setup;
  logic access;
  logic mapped;
  logic [31:0] rdata;
  logic take_c;
  logic take_b;

  // edges are taken from the second stage only, never the first
  // prev trails the second stage by one cycle, so each edge lasts one cycle
  assign k_rise = st.sync2[DPC_SY_KCLK] & ~st.prev[DPC_SY_KCLK]; // RL7
  assign id_rise = st.sync2[DPC_SY_IDCLK] & ~st.prev[DPC_SY_IDCLK];
  assign id_fall = ~st.sync2[DPC_SY_IDCLK] & st.prev[DPC_SY_IDCLK];
  assign cmp_fall = ~st.sync2[DPC_SY_CMP] & st.prev[DPC_SY_CMP];
  assign eref_fall = ~st.sync2[DPC_SY_EREF] & st.prev[DPC_SY_EREF];
  assign mask = dpc_mask(st.mod_sel);
  // masking keeps the count in range after a live modulus change
  assign cur = st.count & mask; // RL6

  // apb decode
  // no wait states: pready follows every setup cycle by one clock
  assign setup = apb_req.psel & ~apb_req.penable;
  assign access = apb_req.psel & apb_req.penable & st.rsp.pready;
  assign mapped = (apb_req.paddr == DPC_CTRL_OFS) | (apb_req.paddr == DPC_STATUS_OFS)
                  | (apb_req.paddr == DPC_COUNT_OFS);

  // read mux, unused bits read as zero
  // the word is captured in setup, so a later pin change cannot tear it
  always_comb
  begin
    rdata = 32'h0000_0000;
    case (apb_req.paddr)
      DPC_CTRL_OFS:
      begin
        rdata[DPC_CTRL_MOD_LSB +: DPC_CTRL_MOD_W] = st.mod_sel;
        rdata[DPC_CTRL_EN_BIT] = st.ctr_en;
      end
      DPC_STATUS_OFS:
      begin
        rdata[DPC_ST_XOR_BIT] = st.xor_out;
        rdata[DPC_ST_EDGE_BIT] = st.edge_out;
        rdata[DPC_ST_AD_BIT] = st.ad_out;
        rdata[DPC_ST_DIR_BIT] = st.dir_q;
        rdata[DPC_ST_CPEND_BIT] = st.carry_pend;
        rdata[DPC_ST_BPEND_BIT] = st.borrow_pend;
      end
      DPC_COUNT_OFS:
      begin
        rdata[DPC_CNT_W-1:0] = st.count;
      end
      default:
      begin
        rdata = 32'h0000_0000;
      end
    endcase
  end

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    take_c = 1'b0;
    take_b = 1'b0;

    // two-stage synchronisers for every loop pin
    // limitation: pin pulses shorter than one pclk cycle may be missed
    next_st.sync1[DPC_SY_XREF] = xor_ref_in;
    next_st.sync1[DPC_SY_EREF] = edge_ref_in;
    next_st.sync1[DPC_SY_CMP] = compare_in;
    next_st.sync1[DPC_SY_KCLK] = loop_filter_counter_clock;
    next_st.sync1[DPC_SY_IDCLK] = add_delete_clock;
    next_st.sync1[DPC_SY_DIR] = count_dir_in;
    next_st.sync2 = st.sync1;
    next_st.prev = st.sync2;

    // xor detector, square wave at quarter-cycle offset
    next_st.xor_out = st.sync2[DPC_SY_XREF] ^ st.sync2[DPC_SY_CMP]; // RL1 RL16

    // edge detector; rising edges leave it alone
    if (cmp_fall)
    begin
      next_st.edge_out = 1'b1; // RL2 RL16
    end
    else if (eref_fall)
    begin
      next_st.edge_out = 1'b0; // RL2
    end

    // loop-filter counter, pulses last one pclk cycle
    // wrap checks use the masked count so a shrunk modulus wraps within its own range
    next_st.carry = 1'b0;
    next_st.borrow = 1'b0;
    if (k_rise)
    begin
      next_st.dir_q = st.sync2[DPC_SY_DIR]; // RL18
    end
    if (k_rise && st.ctr_en && (st.mod_sel != DPC_MOD_RST)) // RL3 RL18
    begin
      if (st.sync2[DPC_SY_DIR])
      begin
        if (cur == '0)
        begin
          next_st.count = mask;
          next_st.borrow = 1'b1; // RL9
        end
        else
        begin
          next_st.count = cur - 17'h0_0001;
        end
      end
      else
      begin
        if (cur == mask)
        begin
          next_st.count = '0;
          next_st.carry = 1'b1; // RL8
        end
        else
        begin
          next_st.count = cur + 17'h0_0001;
        end
      end
    end

    // add/delete stage: toggles on each rising clock edge except while deleting
    // one correction at a time; a second pulse waiting merges into its flag
    case (st.ad_st)
      DPC_AD_IDLE:
      begin
        if (id_rise)
        begin
          next_st.ad_out = ~st.ad_out; // RL11
        end
        // carry served before borrow when both wait
        if (st.carry_pend)
        begin
          take_c = 1'b1;
          next_st.ad_st = DPC_AD_INS1;
        end
        else if (st.borrow_pend)
        begin
          take_b = 1'b1;
          next_st.ad_st = DPC_AD_DEL1;
        end
      end
      DPC_AD_INS1:
      begin
        // extra toggles on falling edges add one whole pulse
        if (id_rise || id_fall)
        begin
          next_st.ad_out = ~st.ad_out; // RL12 RL17
        end
        if (id_fall)
        begin
          next_st.ad_st = DPC_AD_INS2;
        end
      end
      DPC_AD_INS2:
      begin
        if (id_rise || id_fall)
        begin
          next_st.ad_out = ~st.ad_out; // RL12 RL17
        end
        if (id_fall)
        begin
          next_st.ad_st = DPC_AD_IDLE;
        end
      end
      DPC_AD_DEL1:
      begin
        // two skipped toggles remove one whole pulse
        if (id_rise)
        begin
          next_st.ad_st = DPC_AD_DEL2; // RL12 RL17
        end
      end
      DPC_AD_DEL2:
      begin
        if (id_rise)
        begin
          next_st.ad_st = DPC_AD_IDLE; // RL12 RL17
        end
      end
      default:
      begin
        next_st.ad_st = DPC_AD_IDLE;
      end
    endcase

    // a new pulse wins over the take in the same cycle
    next_st.carry_pend = (st.carry_pend & ~take_c) | st.carry; // RL12
    next_st.borrow_pend = (st.borrow_pend & ~take_b) | st.borrow; // RL12

    // apb slave: answer registered in setup, seen in first access cycle
    next_st.rsp.pready = setup;
    next_st.rsp.pslverr = setup & ~mapped;
    if (setup)
    begin
      next_st.rsp.prdata = apb_req.pwrite ? 32'h0000_0000 : rdata;
    end
    // writes land at the access edge only; status and count are read-only
    if (access && apb_req.pwrite && (apb_req.paddr == DPC_CTRL_OFS))
    begin
      next_st.mod_sel = apb_req.pwdata[DPC_CTRL_MOD_LSB +: DPC_CTRL_MOD_W]; // RL6
      next_st.ctr_en = apb_req.pwdata[DPC_CTRL_EN_BIT];
    end
  end

  // -----------------------------------------------------------------
  // state register
  // -----------------------------------------------------------------
  // reset stands in for the power-on clear
  // one struct keeps every flop under a single register process
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st.sync1 <= '0;
      st.sync2 <= '0;
      st.prev <= '0;
      st.xor_out <= 1'b0;
      st.edge_out <= 1'b0;
      st.ad_out <= 1'b0; // RL19
      st.carry <= 1'b0;
      st.borrow <= 1'b0;
      st.carry_pend <= 1'b0;
      st.borrow_pend <= 1'b0;
      st.dir_q <= 1'b0;
      st.ad_st <= DPC_AD_IDLE; // RL19
      st.count <= DPC_CNT_RST; // RL19
      st.mod_sel <= DPC_MOD_RST;
      st.ctr_en <= DPC_EN_RST;
      st.rsp <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  // outputs straight from flops
  assign apb_rsp = st.rsp;
  assign xor_detector_out = st.xor_out;
  assign edge_detector_out = st.edge_out;
  assign add_delete_out = st.ad_out;
  assign carry_out = st.carry;
  assign borrow_out = st.borrow;

endmodule : dpc_core

// [src/dpc_pkg.sv]
// shared constants and types of the digital loop core
// assumes a 32-bit apb master on the same clock as the core
package dpc_pkg;

  // -----------------------------------------------------------------
  // register map
  // -----------------------------------------------------------------
  localparam int unsigned DPC_ADDR_W = 12;
  localparam logic [DPC_ADDR_W-1:0] DPC_CTRL_OFS = 12'h000;
  localparam logic [DPC_ADDR_W-1:0] DPC_STATUS_OFS = 12'h004;
  localparam logic [DPC_ADDR_W-1:0] DPC_COUNT_OFS = 12'h008;

  // control register fields
  localparam int unsigned DPC_CTRL_MOD_LSB = 0;
  localparam int unsigned DPC_CTRL_MOD_W = 4;
  localparam int unsigned DPC_CTRL_EN_BIT = 4;
  localparam logic [3:0] DPC_MOD_RST = 4'h0;
  localparam logic DPC_EN_RST = 1'b0;

  // status register fields
  localparam int unsigned DPC_ST_XOR_BIT = 0;
  localparam int unsigned DPC_ST_EDGE_BIT = 1;
  localparam int unsigned DPC_ST_AD_BIT = 2;
  localparam int unsigned DPC_ST_DIR_BIT = 3;
  localparam int unsigned DPC_ST_CPEND_BIT = 4;
  localparam int unsigned DPC_ST_BPEND_BIT = 5;

  // -----------------------------------------------------------------
  // loop-filter counter and synchroniser layout
  // -----------------------------------------------------------------
  localparam int unsigned DPC_CNT_W = 17;
  localparam int unsigned DPC_MOD_OFFSET = 2;
  localparam logic [DPC_CNT_W-1:0] DPC_CNT_RST = 17'h0_0000;
  localparam int unsigned DPC_NSYNC = 6;
  localparam int unsigned DPC_SY_XREF = 0;
  localparam int unsigned DPC_SY_EREF = 1;
  localparam int unsigned DPC_SY_CMP = 2;
  localparam int unsigned DPC_SY_KCLK = 3;
  localparam int unsigned DPC_SY_IDCLK = 4;
  localparam int unsigned DPC_SY_DIR = 5;

  // add/delete stage states
  typedef enum logic [2:0] {
    DPC_AD_IDLE = 3'b000,
    DPC_AD_INS1 = 3'b001,
    DPC_AD_INS2 = 3'b010,
    DPC_AD_DEL1 = 3'b011,
    DPC_AD_DEL2 = 3'b100
  } dpc_ad_e;

  // apb request and answer carriers
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [DPC_ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } dpc_apb_req_s;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } dpc_apb_rsp_s;

endpackage : dpc_pkg

// [testbench/digital_pll_core_bench.sv]
// bench: self-checking run of the loop core
// assumes dpc_core, dpc_chk and dpc_loop_partner are compiled first
`timescale 1ns/1ps
module digital_pll_core_bench;
  import dpc_pkg::*;
  logic pclk = 0, presetn = 0, xref = 0, eref = 0, cmp_tb = 0, kclk = 0, idclk = 0;
  logic dir_tb = 0, loop_on = 0, ado_q = 0, cmp_q = 0, perr;
  logic xo, eo, ado, co, bo, pcmp, pdir;
  logic [31:0] q;
  dpc_apb_req_s req = '0;
  dpc_apb_rsp_s rsp;
  int n_errors = 0, compares = 0, cyc = 0, n_c = 0, n_b = 0, n_t = 0, n_f = 0, k0;
  logic [2:0] rows [4] = '{3'b000, 3'b011, 3'b101, 3'b110}; // xref, cmp, xor out
  dpc_core u_dpc_core (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .xor_ref_in(xref), .edge_ref_in(eref), .compare_in(loop_on ? pcmp : cmp_tb),
    .loop_filter_counter_clock(kclk), .add_delete_clock(idclk),
    .count_dir_in(loop_on ? pdir : dir_tb), .xor_detector_out(xo),
    .edge_detector_out(eo), .add_delete_out(ado), .carry_out(co), .borrow_out(bo));
  dpc_loop_partner u_dpc_loop_partner (.presetn(presetn), .add_delete_out(ado),
    .xor_detector_out(xo), .compare_out(pcmp), .dir_out(pdir));
  // -----------------------------------------------------------------
  // clock, timeout and event counters
  // -----------------------------------------------------------------
  initial
  begin
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    ado_q <= ado;
    cmp_q <= pcmp;
    n_c <= n_c + (co === 1'b1);
    n_b <= n_b + (bo === 1'b1);
    n_t <= n_t + (ado !== ado_q);
    n_f <= n_f + (pcmp !== cmp_q);
    if (cyc == 5000)
    begin
      n_errors++;
      close_out();
    end
  end
  task close_out();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one apb transfer; holds the request until ready is sampled
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    // no local limit: only the global cycle ceiling ends a hung wait
    do
    begin
      @(posedge pclk);
    end
    while (rsp.pready !== 1'b1);
    q = rsp.prdata;
    perr = rsp.pslverr;
    req <= '0;
  endtask : apb
  // slow pin clocks: nk counter clock periods, then ni a/d clock periods
  task run(input int nk, input int ni);
    repeat (2 * nk)
    begin
      repeat (5) @(posedge pclk);
      kclk <= ~kclk;
    end
    repeat (2 * ni)
    begin
      repeat (5) @(posedge pclk);
      idclk <= ~idclk;
    end
    repeat (10) @(posedge pclk);
  endtask : run
  task ad(input int e);
    k0 = n_t;
    run(0, 8);
    chk("a/d toggles", k0 + e, n_t);
  endtask : ad
  task cnt(input logic [16:0] e, input int nc, input int nb);
    apb(0, DPC_COUNT_OFS, 0);
    chk("count", e, q);
    chk("carries", nc, n_c);
    chk("borrows", nb, n_b);
  endtask : cnt
  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, DPC_CTRL_OFS, 0);
    chk("ctrl reset", 0, q);
    apb(0, 12'h010, 0);
    chk("unmapped err", 1, perr);
    foreach (rows[i])
    begin
      xref <= rows[i][2];
      cmp_tb <= rows[i][1];
      repeat (8) @(posedge pclk);
      chk("xor out", rows[i][0], xo);
    end
    xref <= 1'b0;
    eref <= 1'b1;
    repeat (8) @(posedge pclk);
    chk("edge hold", 1, eo);
    eref <= 1'b0;
    repeat (8) @(posedge pclk);
    chk("edge clear", 0, eo);
    ad(8);
    apb(1, DPC_CTRL_OFS, 32'h0000_0011);
    run(8, 0);
    cnt(0, 1, 0);
    ad(10);
    dir_tb <= 1'b1;
    run(1, 0);
    cnt(7, 1, 1);
    ad(6);
    dir_tb <= 1'b0;
    run(1, 0);
    apb(1, DPC_CTRL_OFS, 32'h0000_001f);
    dir_tb <= 1'b1;
    run(1, 0);
    cnt(17'h1_ffff, 2, 2);
    ad(8);
    apb(1, DPC_CTRL_OFS, 32'h0000_0010);
    run(3, 0);
    cnt(17'h1_ffff, 2, 2);
    apb(1, DPC_CTRL_OFS, 32'h0000_000f);
    run(2, 0);
    cnt(17'h1_ffff, 2, 2);
    apb(0, DPC_CTRL_OFS, 0);
    chk("ctrl readback", 32'h0000_000f, q);
    // xor out high, edge out low, even toggle count, direction down, nothing pending
    apb(0, DPC_STATUS_OFS, 0);
    chk("status", 32'h0000_0009, q);
    loop_on <= 1'b1;
    repeat (8) @(posedge pclk);
    k0 = n_f;
    run(0, 16);
    chk("feedback toggles", k0 + 4, n_f);
    // mid-run reset must clear the counter and control state again
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, DPC_COUNT_OFS, 0);
    chk("count reset", 0, q);
    apb(0, DPC_CTRL_OFS, 0);
    chk("ctrl after reset", 0, q);
    close_out();
  end
endmodule : digital_pll_core_bench
bind dpc_core dpc_chk u_dpc_chk (.pclk, .presetn, .apb_req, .apb_rsp, .xor_ref_in,
  .edge_ref_in, .compare_in, .add_delete_clock, .xor_detector_out, .edge_detector_out,
  .add_delete_out, .carry_out, .borrow_out);

// [testbench/dpc_chk.sv]
// checker: timing relations at the loop core ports
// assumes it is bound to dpc_core by the bench
`timescale 1ns/1ps
module dpc_chk
  import dpc_pkg::*;
(
  input wire logic pclk, // clock
  input wire logic presetn, // reset
  input wire dpc_pkg::dpc_apb_req_s apb_req, // request
  input wire dpc_pkg::dpc_apb_rsp_s apb_rsp, // answer
  input wire logic xor_ref_in, // xor ref
  input wire logic edge_ref_in, // edge ref
  input wire logic compare_in, // feedback
  input wire logic add_delete_clock, // a/d clock
  input wire logic xor_detector_out, // xor out
  input wire logic edge_detector_out, // edge out
  input wire logic add_delete_out, // a/d out
  input wire logic carry_out, // carry
  input wire logic borrow_out // borrow
);
  logic [4:0] ctrl;
  logic inh;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // -----------------------------------------------------------------
  // control shadow
  // -----------------------------------------------------------------
  // shadow of completed writes, needed to know when counting is off
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      ctrl <= '0;
    else if (apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite
             && apb_req.paddr == DPC_CTRL_OFS)
      ctrl <= apb_req.pwdata[4:0];
  assign inh = ctrl[3:0] == 4'h0 || !ctrl[4];
  sequence s_setup;
    apb_req.psel && !apb_req.penable;
  endsequence
  sequence s_edge_quiet;
    (!$fell(compare_in) && !$fell(edge_ref_in)) [*6];
  endsequence
  // -----------------------------------------------------------------
  // properties
  // -----------------------------------------------------------------
  a_xor_level: assert property (($stable(xor_ref_in ^ compare_in)) [*5] |->
    xor_detector_out == (xor_ref_in ^ compare_in)) else $error("xor out wrong");
  a_edge_set: assert property ($fell(compare_in) |-> ##[2:5] edge_detector_out)
    else $error("edge out not set");
  a_edge_clear: assert property ($fell(edge_ref_in) |-> ##[2:5] !edge_detector_out)
    else $error("edge out not cleared");
  a_edge_hold: assert property (s_edge_quiet |=> $stable(edge_detector_out))
    else $error("edge out moved");
  a_inhibit_quiet: assert property (inh [*6] |-> !carry_out && !borrow_out)
    else $error("pulse while inhibited");
  a_carry_single: assert property (carry_out |=> !carry_out && !borrow_out)
    else $error("carry not single");
  a_borrow_single: assert property (borrow_out |=> !borrow_out && !carry_out)
    else $error("borrow not single");
  a_ad_quiet: assert property (($stable(add_delete_clock)) [*6] |=>
    $stable(add_delete_out)) else $error("a/d out moved");
  a_apb_ready: assert property (s_setup |=> apb_rsp.pready) else $error("no ready");
endmodule : dpc_chk

// [testbench/dpc_loop_partner.sv]
// partner: outside divide-by-N counter and direction routing
// assumes add_delete_out of the core clocks the divider
`timescale 1ns/1ps
module dpc_loop_partner #(
  parameter int N = 4 // divider ratio, plain default
)
(
  input wire logic presetn, // reset
  input wire logic add_delete_out, // core a/d out
  input wire logic xor_detector_out, // core xor out
  output logic compare_out, // divided feedback
  output logic dir_out // count direction
);
  int cnt;
  // the core has no divider of its own, so the loop closes here
  always @(posedge add_delete_out or negedge presetn)
    if (!presetn)
    begin
      cnt <= 0;
      compare_out <= 1'b0;
    end
    else
    begin
      cnt <= (cnt == N / 2 - 1) ? 0 : cnt + 1;
      if (cnt == N / 2 - 1)
        compare_out <= !compare_out;
    end
  assign dir_out = xor_detector_out;
endmodule : dpc_loop_partner
